// [hdl/pmc_consts.svh]
// Constants for the power mode controller: reset-cause codes, SRAM layout,
// wake latencies. Included by the package users; definitions only.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_CLK_MHZ 100
`define PMC_IDLE_WAKE_US 14
`define PMC_STBY_WAKE_US 151
`define PMC_SHDN_WAKE_US 1015
`define PMC_IDLE_WAKE_CYC (`PMC_IDLE_WAKE_US * `PMC_CLK_MHZ)
`define PMC_STBY_WAKE_CYC (`PMC_STBY_WAKE_US * `PMC_CLK_MHZ)
`define PMC_SHDN_WAKE_CYC (`PMC_SHDN_WAKE_US * `PMC_CLK_MHZ)
`define PMC_SRAM_BLOCKS 4
`define PMC_SRAM_SMALL_KB 4
`define PMC_SRAM_LARGE_KB 6
`define PMC_CACHE_KB 8
`define PMC_CAUSE_POR 2'h0
`define PMC_CAUSE_PIN 2'h1
`define PMC_CAUSE_SHDN_WAKE 2'h2
`define PMC_CAUSE_BOD 2'h3
`define PMC_BOD_ON_CYC 16'h0010
`define PMC_BOD_PERIOD_CYC 16'h0400
`endif

// [hdl/pmc_pkg.sv]
// Types for the power mode controller.
// Assumes pmc_consts.svh supplies numeric constants.
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_REQ_ACTIVE = 2'h0,
    PMC_REQ_IDLE = 2'h1,
    PMC_REQ_STANDBY = 2'h2,
    PMC_REQ_SHUTDOWN = 2'h3
  } pmc_req_t;
  typedef enum logic [6:0] {
    PMC_ST_ACTIVE = 7'h01,
    PMC_ST_IDLE = 7'h02,
    PMC_ST_STANDBY = 7'h04,
    PMC_ST_SHUTDOWN = 7'h08,
    PMC_ST_HELD = 7'h10,
    PMC_ST_WAKE = 7'h20,
    PMC_ST_LOCKED = 7'h40
  } pmc_state_t;
endpackage : pmc_pkg

// [hdl/pmc_wake_if.sv]
// Carries the wake-latency timer request and done between controller and timer.
`timescale 1ns/1ps
`default_nettype none
interface pmc_wake_if;
  logic start;
  logic [17:0] count;
  logic done;
  modport ctrl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : pmc_wake_if
`default_nettype wire

// [hdl/pmc_wake_timer.sv]
// Down-counter that times wake-up latency.
// Assumes start is a single-cycle pulse while the timer is idle.
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_timer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  pmc_wake_if.tmr wk
);
  logic [17:0] cnt;
  logic [17:0] next_cnt;
  logic busy;
  logic next_busy;
  logic done_q;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (wk.start) begin
      next_cnt = wk.count;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt <= 18'h00001) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - 18'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt <= 18'h00000;
      busy <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      cnt <= next_cnt;
      busy <= next_busy;
      done_q <= next_done;
    end
  end

  assign wk.done = done_q;
endmodule : pmc_wake_timer
`default_nettype wire

// [hdl/pmc_power_mode_controller.sv]
// Power mode controller: sequences active, idle, standby, shutdown, held reset.
// Assumes all inputs synchronous to ref_clk; power switches and clock gates
// outside act on the enables driven here.
//
// Summary of operation
// - Four software modes plus a held state while the reset pin is asserted.
// - Active mode: processor runs, enabled peripherals clocked, any clock source.
// - Idle gates processor core and memory clocks, peripherals keep clocks.
// - Any interrupt returns idle to active.
// - Standby keeps only always-on domain; pin, clock or sensor event wakes.
// - Standby wake resumes execution; retained peripherals keep configuration.
// - All general-purpose pins held latched throughout standby.
// - Shutdown powers off everything including always-on domain and sensor engine.
// - Pins latched at prior value on shutdown entry; only these and flash survive.
// - Level change on a shutdown wake pin wakes device as a reset.
// - Reset cause register tells shutdown wake, reset pin and power-on apart.
// - SRAM has two 4-KB and two 6-KB blocks with own retention enables.
// - Disabled flash cache exposes its 8-KB storage as general RAM.
// - Wake latency about 14, 151 and 1015 microseconds.
// - Brown-out detector duty-cycled in standby; missed undervoltage locks until reset.
// - Sensor engine individually enabled during standby.
// - Sensor engine runs alone, waking processor only on configured conditions.
// - Comparator wakes device from idle or standby while it is active.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_power_mode_controller #(
  parameter int NUM_PINS = 31,
  parameter int IDLE_WAKE_CYC = `PMC_IDLE_WAKE_CYC,
  parameter int STBY_WAKE_CYC = `PMC_STBY_WAKE_CYC,
  parameter int SHDN_WAKE_CYC = `PMC_SHDN_WAKE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic por_event,
  input wire logic reset_pin_held,
  input wire logic [1:0] mode_req,
  input wire logic sleep_req,
  input wire logic irq_any,
  input wire logic rtc_event,
  input wire logic ext_wake_event,
  input wire logic sensor_wake,
  input wire logic sensor_en_stby,
  input wire logic comp_active,
  input wire logic comp_out,
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] gpio_out_sw,
  input wire logic [NUM_PINS-1:0] shdn_wake_en,
  input wire logic [`PMC_SRAM_BLOCKS-1:0] sram_ret_en,
  input wire logic cache_disable,
  input wire logic bod_trip,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic hf_clk_en,
  output logic aon_pwr_en,
  output logic main_pwr_en,
  output logic sensor_pwr_en,
  output logic [`PMC_SRAM_BLOCKS-1:0] sram_pwr_en,
  output logic cache_as_ram,
  output logic gpio_latch,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic brown_out_detector_en,
  output logic cpu_reset,
  output logic cpu_resume,
  output logic comp_irq,
  output logic comp_adc_trig,
  output logic [1:0] reset_cause,
  output logic [6:0] mode_state,
  output logic locked
);
  initial begin
    if (NUM_PINS < 1 || NUM_PINS > 64) $error("NUM_PINS out of range");
    if (SHDN_WAKE_CYC >= (1 << 18) || IDLE_WAKE_CYC < 1) $error("wake count");
  end

  pmc_wake_if wk ();
  pmc_wake_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wk(wk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  pmc_pkg::pmc_state_t st;
  pmc_pkg::pmc_state_t next_st;
  logic [1:0] cause;
  logic [1:0] next_cause;
  logic [NUM_PINS-1:0] pin_hold;
  logic [NUM_PINS-1:0] next_pin_hold;
  logic [NUM_PINS-1:0] wake_ref;
  logic [NUM_PINS-1:0] next_wake_ref;
  logic resume_pend;
  logic next_resume_pend;
  logic resume_q;
  logic next_resume_q;
  logic bod_missed;
  logic next_bod_missed;
  logic [15:0] bod_cnt;
  logic [15:0] next_bod_cnt;
  logic start_q;
  logic next_start;
  logic [17:0] cnt_q;
  logic [17:0] next_cnt;

  function automatic logic [17:0] cyc18(input int c);
    cyc18 = c[17:0];
  endfunction : cyc18

  // Comparator counts as a wake only while it is powered
  logic comp_wake;
  assign comp_wake = comp_active & comp_out;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_cause = cause;
    next_pin_hold = pin_hold;
    next_wake_ref = wake_ref;
    next_resume_pend = resume_pend;
    next_resume_q = 1'b0;
    next_bod_missed = bod_missed;
    next_bod_cnt = bod_cnt;
    next_start = 1'b0;
    next_cnt = cnt_q;
    if (por_event) begin
      next_st = pmc_pkg::PMC_ST_WAKE;
      next_cause = `PMC_CAUSE_POR;
      next_bod_missed = 1'b0;
      next_resume_pend = 1'b0;
      next_start = 1'b1;
      next_cnt = cyc18(SHDN_WAKE_CYC);
    end else if (reset_pin_held) begin
      next_st = pmc_pkg::PMC_ST_HELD;
      next_cause = `PMC_CAUSE_PIN;
      next_bod_missed = 1'b0;
      next_resume_pend = 1'b0;
    end else begin
      case (st)
        pmc_pkg::PMC_ST_ACTIVE: begin
          // Request is taken only with the sleep instruction
          if (sleep_req) begin
            case (pmc_pkg::pmc_req_t'(mode_req))
              pmc_pkg::PMC_REQ_IDLE: next_st = pmc_pkg::PMC_ST_IDLE;
              pmc_pkg::PMC_REQ_STANDBY: begin
                next_st = pmc_pkg::PMC_ST_STANDBY;
                next_pin_hold = gpio_out_sw;
                next_bod_cnt = 16'h0000;
              end
              pmc_pkg::PMC_REQ_SHUTDOWN: begin
                next_st = pmc_pkg::PMC_ST_SHUTDOWN;
                next_pin_hold = gpio_out_sw;
                next_wake_ref = gpio_in;
              end
              default: next_st = pmc_pkg::PMC_ST_ACTIVE;
            endcase
          end
        end
        pmc_pkg::PMC_ST_IDLE: begin
          if (irq_any || comp_wake) begin
            next_st = pmc_pkg::PMC_ST_WAKE;
            next_resume_pend = 1'b1;
            next_start = 1'b1;
            next_cnt = cyc18(IDLE_WAKE_CYC);
          end
        end
        pmc_pkg::PMC_ST_STANDBY: begin
          // Detector only samples during its on window
          next_bod_cnt = (bod_cnt >= `PMC_BOD_PERIOD_CYC - 16'h0001) ? 16'h0000
                         : bod_cnt + 16'h0001;
          if (bod_trip && bod_cnt >= `PMC_BOD_ON_CYC) next_bod_missed = 1'b1;
          if (ext_wake_event || rtc_event || (sensor_en_stby && sensor_wake)
              || comp_wake) begin
            next_st = pmc_pkg::PMC_ST_WAKE;
            next_resume_pend = 1'b1;
            next_start = 1'b1;
            next_cnt = cyc18(STBY_WAKE_CYC);
          end
        end
        pmc_pkg::PMC_ST_SHUTDOWN: begin
          if (|((gpio_in ^ wake_ref) & shdn_wake_en)) begin
            next_st = pmc_pkg::PMC_ST_WAKE;
            next_cause = `PMC_CAUSE_SHDN_WAKE;
            next_resume_pend = 1'b0;
            next_start = 1'b1;
            next_cnt = cyc18(SHDN_WAKE_CYC);
          end
        end
        pmc_pkg::PMC_ST_HELD: begin
          next_st = pmc_pkg::PMC_ST_WAKE;
          next_start = 1'b1;
          next_cnt = cyc18(SHDN_WAKE_CYC);
        end
        pmc_pkg::PMC_ST_WAKE: begin
          if (wk.done) begin
            next_st = bod_missed ? pmc_pkg::PMC_ST_LOCKED : pmc_pkg::PMC_ST_ACTIVE;
            next_resume_q = resume_pend & ~bod_missed;
            next_resume_pend = 1'b0;
          end
        end
        pmc_pkg::PMC_ST_LOCKED: next_st = pmc_pkg::PMC_ST_LOCKED;
        default: next_st = pmc_pkg::PMC_ST_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= pmc_pkg::PMC_ST_ACTIVE;
      cause <= `PMC_CAUSE_POR;
      pin_hold <= '0;
      wake_ref <= '0;
      resume_pend <= 1'b0;
      resume_q <= 1'b0;
      bod_missed <= 1'b0;
      bod_cnt <= 16'h0000;
      start_q <= 1'b0;
      cnt_q <= 18'h00000;
    end else if (clk_en) begin
      st <= next_st;
      cause <= next_cause;
      pin_hold <= next_pin_hold;
      wake_ref <= next_wake_ref;
      resume_pend <= next_resume_pend;
      resume_q <= next_resume_q;
      bod_missed <= next_bod_missed;
      bod_cnt <= next_bod_cnt;
      start_q <= next_start;
      cnt_q <= next_cnt;
    end
  end

  assign wk.start = start_q & clk_en;
  assign wk.count = cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, decoded from registered state and the control inputs
  logic in_act;
  logic in_idle;
  logic in_stby;
  logic pins_latched;
  assign in_act = (st == pmc_pkg::PMC_ST_ACTIVE);
  assign in_idle = (st == pmc_pkg::PMC_ST_IDLE);
  assign in_stby = (st == pmc_pkg::PMC_ST_STANDBY);
  assign pins_latched = in_stby || (st == pmc_pkg::PMC_ST_SHUTDOWN);

  assign cpu_clk_en = in_act;
  assign mem_clk_en = in_act;
  assign periph_clk_en = in_act | in_idle;
  assign hf_clk_en = in_act | in_idle;
  assign main_pwr_en = in_act | in_idle | (st == pmc_pkg::PMC_ST_WAKE);
  // Always-on domain drops only in shutdown and while held in reset
  assign aon_pwr_en = ~((st == pmc_pkg::PMC_ST_SHUTDOWN) | (st == pmc_pkg::PMC_ST_HELD));
  assign sensor_pwr_en = in_act | in_idle | (in_stby & sensor_en_stby);
  // Non-retained blocks lose power in standby; all off in shutdown
  assign sram_pwr_en = aon_pwr_en ? (in_stby ? sram_ret_en : {`PMC_SRAM_BLOCKS{1'b1}})
                       : {`PMC_SRAM_BLOCKS{1'b0}};
  assign cache_as_ram = cache_disable & main_pwr_en;
  assign gpio_latch = pins_latched;
  assign gpio_out = pins_latched ? pin_hold : gpio_out_sw;
  assign brown_out_detector_en = in_stby ? (bod_cnt < `PMC_BOD_ON_CYC) : aon_pwr_en;
  assign cpu_reset = ~(in_act | in_idle) & ~resume_pend & ~in_stby;
  assign cpu_resume = resume_q;
  assign comp_irq = comp_wake;
  assign comp_adc_trig = comp_wake;
  assign reset_cause = cause;
  assign mode_state = st;
  assign locked = (st == pmc_pkg::PMC_ST_LOCKED);
endmodule : pmc_power_mode_controller
`default_nettype wire

// [verif/pmc_props.sv]
// Port-level assertions for the power mode controller.
// Assumes a bind onto the top module; everything runs on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pmc_props #(
  parameter int NUM_PINS = 31
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic por_event,
  input wire logic reset_pin_held,
  input wire logic irq_any,
  input wire logic rtc_event,
  input wire logic ext_wake_event,
  input wire logic comp_active,
  input wire logic comp_out,
  input wire logic [3:0] sram_ret_en,
  input wire logic cache_disable,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic aon_pwr_en,
  input wire logic main_pwr_en,
  input wire logic sensor_pwr_en,
  input wire logic [3:0] sram_pwr_en,
  input wire logic cache_as_ram,
  input wire logic gpio_latch,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic cpu_resume,
  input wire logic comp_irq,
  input wire logic [1:0] reset_cause,
  input wire logic [6:0] mode_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Reset-pin and power-on requests outrank every mode request
  wire go = clk_en && !por_event && !reset_pin_held;
  ////////////////////////////////////////////////////////////////////////////
  property p_gate; cpu_clk_en == mode_state[0] && periph_clk_en == |mode_state[1:0]; endproperty
  a_gate: assert property (p_gate) else $error("clock gating wrong");
  property p_idle; mode_state == 7'h02 && irq_any && go |=>
    mode_state == 7'h20 ##[2:14] mode_state == 7'h01; endproperty
  a_idle: assert property (p_idle) else $error("idle wake wrong");
  property p_stby; mode_state == 7'h04 && (rtc_event || ext_wake_event) && go |=>
    mode_state == 7'h20; endproperty
  a_stby: assert property (p_stby) else $error("standby wake missed");
  property p_latch; mode_state[2] && $past(mode_state[2]) |-> gpio_latch && $stable(gpio_out);
  endproperty
  a_latch: assert property (p_latch) else $error("pins not held");
  property p_shdn; mode_state[3] |-> !aon_pwr_en && !sensor_pwr_en && !main_pwr_en &&
    sram_pwr_en == 4'h0 && gpio_latch; endproperty
  a_shdn: assert property (p_shdn) else $error("shutdown power wrong");
  property p_sram; mode_state[2] |-> sram_pwr_en == sram_ret_en; endproperty
  a_sram: assert property (p_sram) else $error("retention wrong");
  property p_cache; cache_as_ram == (cache_disable && main_pwr_en); endproperty
  a_cache: assert property (p_cache) else $error("cache ram wrong");
  property p_held; reset_pin_held && !por_event && clk_en |=>
    mode_state == 7'h10 ##[0:1] reset_cause == 2'h1; endproperty
  a_held: assert property (p_held) else $error("held reset wrong");
  property p_comp; comp_irq == (comp_active && comp_out); endproperty
  a_comp: assert property (p_comp) else $error("comparator irq wrong");
  property p_resume; cpu_resume |=> !cpu_resume; endproperty
  a_resume: assert property (p_resume) else $error("resume too long");
endmodule : pmc_props
`default_nettype wire

// [verif/pmc_wake_model.sv]
// Model of software interrupts and external wake sources.
// Assumes fire() is called just after a falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_model (
  input wire logic ref_clk,
  output logic irq_any,
  output logic rtc_event,
  output logic ext_wake_event,
  output logic sensor_wake,
  output logic comp_out
);
  initial {comp_out, sensor_wake, ext_wake_event, rtc_event, irq_any} = 5'h00;
  // Source k: 0 irq, 1 clock, 2 pin, 3 sensor, 4 comparator; hold > 1 acts slowly
  task automatic fire(input int k, input int hold);
    {comp_out, sensor_wake, ext_wake_event, rtc_event, irq_any} = 5'h01 << k;
    repeat (hold) @(negedge ref_clk);
    {comp_out, sensor_wake, ext_wake_event, rtc_event, irq_any} = 5'h00;
  endtask : fire
endmodule : pmc_wake_model
`default_nettype wire

// [verif/pmc_power_mode_controller_tb.sv]
// Self-checking bench: queued mode expectations against a state monitor.
// Assumes the package, header and wake model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_power_mode_controller_tb;
  logic ref_clk, reset, por_event, reset_pin_held, sleep_req, sensor_en_stby, comp_active;
  logic cache_disable, bod_trip, irq_any, rtc_event, ext_wake_event, sensor_wake, comp_out;
  logic cpu_clk_en, aon_pwr_en, bod_en, locked, clk_en;
  logic [1:0] mode_req, reset_cause;
  logic [3:0] sram_ret_en, sram_pwr_en;
  logic [6:0] mode_state, last_state;
  logic [30:0] gpio_in, gpio_out_sw, shdn_wake_en, gpio_out, held_out;
  logic [6:0] exp_q[$];
  int fails = 0, total_checks = 0, n;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  pmc_power_mode_controller #(.IDLE_WAKE_CYC(5), .STBY_WAKE_CYC(10), .SHDN_WAKE_CYC(20)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .por_event(por_event),
    .reset_pin_held(reset_pin_held), .mode_req(mode_req), .sleep_req(sleep_req),
    .irq_any(irq_any), .rtc_event(rtc_event), .ext_wake_event(ext_wake_event),
    .sensor_wake(sensor_wake), .sensor_en_stby(sensor_en_stby), .comp_active(comp_active),
    .comp_out(comp_out), .gpio_in(gpio_in), .gpio_out_sw(gpio_out_sw),
    .shdn_wake_en(shdn_wake_en), .sram_ret_en(sram_ret_en), .cache_disable(cache_disable),
    .bod_trip(bod_trip), .cpu_clk_en(cpu_clk_en), .mem_clk_en(), .periph_clk_en(),
    .hf_clk_en(), .aon_pwr_en(aon_pwr_en), .main_pwr_en(), .sensor_pwr_en(),
    .sram_pwr_en(sram_pwr_en), .cache_as_ram(), .gpio_latch(), .gpio_out(gpio_out),
    .brown_out_detector_en(bod_en), .cpu_reset(), .cpu_resume(), .comp_irq(),
    .comp_adc_trig(), .reset_cause(reset_cause), .mode_state(mode_state), .locked(locked));
  pmc_wake_model wake_u (.ref_clk(ref_clk), .irq_any(irq_any), .rtc_event(rtc_event),
    .ext_wake_event(ext_wake_event), .sensor_wake(sensor_wake), .comp_out(comp_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_for(input logic [6:0] st);
    for (int i = 0; i < 300 && mode_state !== st; i++) @(negedge ref_clk);
    if (mode_state !== st) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_for
  task automatic sleep_to(input logic [1:0] m, input logic [6:0] st);
    if (st != 7'h01) exp_q.push_back(st);
    mode_req = m;
    sleep_req = 1'b1;
    @(negedge ref_clk);
    sleep_req = 1'b0;
    wait_for(st);
  endtask : sleep_to
  task automatic wake(input int k, input int hold, input logic [6:0] fin);
    exp_q.push_back(7'h20);
    exp_q.push_back(fin);
    wake_u.fire(k, hold);
    wait_for(fin);
  endtask : wake
  // Every state change must have been announced by the driver
  always @(negedge ref_clk) begin
    if (!reset && mode_state !== last_state) begin
      if (exp_q.size() == 0) chk(32'(mode_state), 32'hFFFFFFFF);
      else chk(32'(mode_state), 32'(exp_q.pop_front()));
      last_state = mode_state;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, last_state, clk_en} = {1'b1, 7'h01, 1'b1};
    {por_event, reset_pin_held, sleep_req, sensor_en_stby, comp_active, bod_trip} = 6'h00;
    {mode_req, gpio_in, gpio_out_sw, shdn_wake_en, sram_ret_en, cache_disable} = '0;
    n = $urandom(32'h798ab2e6);
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    chk(32'(mode_state), 32'h1);
    chk(32'(cpu_clk_en), 32'h1);
    // Frozen clock enable: a sleep pulse must not be taken
    clk_en = 1'b0;
    mode_req = 2'h1;
    sleep_req = 1'b1;
    @(negedge ref_clk);
    sleep_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    clk_en = 1'b1;
    @(negedge ref_clk);
    chk(32'(mode_state), 32'h1);
    sleep_to(2'h0, 7'h01);
    sleep_to(2'h1, 7'h02);
    chk(32'(cpu_clk_en), 32'h0);
    wake(0, 1, 7'h01);
    $display("test idle done");
    for (n = 1; n < 5; n++) begin
      {sram_ret_en, cache_disable, gpio_out_sw} = $urandom();
      sensor_en_stby = (n == 3);
      comp_active = (n == 4);
      sleep_to(2'h2, 7'h04);
      held_out = gpio_out_sw;
      gpio_out_sw = ~held_out;
      if (n == 1) wake_u.fire(3, 2);
      @(negedge ref_clk);
      chk(32'(gpio_out), 32'(held_out));
      chk(32'(sram_pwr_en), 32'(sram_ret_en));
      wake(n, n, 7'h01);
      chk(32'(gpio_out), 32'(gpio_out_sw));
    end
    $display("test standby wakes done");
    sleep_to(2'h2, 7'h04);
    repeat (1100) @(negedge ref_clk);
    n = 0;
    repeat (1024) begin
      @(negedge ref_clk);
      n += bod_en;
    end
    chk(32'(n), `PMC_BOD_ON_CYC);
    for (int i = 0; i < 1100 && bod_en; i++) @(negedge ref_clk);
    bod_trip = 1'b1;
    @(negedge ref_clk);
    bod_trip = 1'b0;
    wake(1, 1, 7'h40);
    chk(32'(locked), 32'h1);
    exp_q.push_back(7'h10);
    reset_pin_held = 1'b1;
    wait_for(7'h10);
    chk(32'(reset_cause), 32'h1);
    exp_q.push_back(7'h20);
    exp_q.push_back(7'h01);
    reset_pin_held = 1'b0;
    wait_for(7'h01);
    $display("test brown out and held reset done");
    {gpio_in, gpio_out_sw} = {$urandom(), $urandom()};
    {shdn_wake_en, held_out} = {31'h10, gpio_out_sw};
    sleep_to(2'h3, 7'h08);
    chk(32'(aon_pwr_en), 32'h0);
    gpio_out_sw = ~held_out;
    gpio_in[5] = ~gpio_in[5];
    repeat (3) @(negedge ref_clk);
    chk(32'(gpio_out), 32'(held_out));
    exp_q.push_back(7'h20);
    exp_q.push_back(7'h01);
    gpio_in[4] = ~gpio_in[4];
    wait_for(7'h01);
    chk(32'(reset_cause), 32'h2);
    exp_q.push_back(7'h20);
    exp_q.push_back(7'h01);
    por_event = 1'b1;
    @(negedge ref_clk);
    por_event = 1'b0;
    wait_for(7'h01);
    chk(32'(reset_cause), 32'h0);
    $display("test shutdown and power-on done");
    report_and_stop();
  end
endmodule : pmc_power_mode_controller_tb
bind pmc_power_mode_controller pmc_props #(.NUM_PINS(NUM_PINS)) props_u (
  .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .por_event(por_event),
  .reset_pin_held(reset_pin_held), .irq_any(irq_any), .rtc_event(rtc_event),
  .ext_wake_event(ext_wake_event), .comp_active(comp_active), .comp_out(comp_out),
  .sram_ret_en(sram_ret_en), .cache_disable(cache_disable), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .aon_pwr_en(aon_pwr_en), .main_pwr_en(main_pwr_en),
  .sensor_pwr_en(sensor_pwr_en), .sram_pwr_en(sram_pwr_en), .cache_as_ram(cache_as_ram),
  .gpio_latch(gpio_latch), .gpio_out(gpio_out), .cpu_resume(cpu_resume),
  .comp_irq(comp_irq), .reset_cause(reset_cause), .mode_state(mode_state));
`default_nettype wire
